// file: shared/orpc_pkg.sv
// constants for the oscillator, real-time counter and power sequencer block
package orpc_pkg;
    localparam logic [2:0] PERIPH_OSC = 3'h4;
    localparam logic [2:0] PERIPH_RTC = 3'h5;
    localparam logic [2:0] PERIPH_PWR = 3'h6;

    localparam logic [7:0] OSC_SOURCE_SELECT    = 8'h00;
    localparam logic [7:0] INTERNAL_OSC_CONTROL = 8'h01;
    localparam logic [7:0] CRYSTAL_OSC_CONTROL  = 8'h02;

    localparam logic [7:0] RTC_COUNT_LOW  = 8'h00;
    localparam logic [7:0] RTC_COUNT_HIGH = 8'h04;

    localparam logic [7:0] POWER_GENERAL_CONTROL = 8'h00;
    localparam logic [7:0] WAKE_TIME_LOW         = 8'h04;
    localparam logic [7:0] WAKE_TIME_HIGH        = 8'h08;
    localparam logic [7:0] SUPPLY_CFG_ASLEEP     = 8'h0C;
    localparam logic [7:0] SUPPLY_CFG_WAKING_A   = 8'h10;
    localparam logic [7:0] SUPPLY_CFG_WAKING_B   = 8'h14;
    localparam logic [7:0] SUPPLY_CFG_AWAKE      = 8'h18;
    localparam logic [7:0] SUPPLY_CFG_SLEEPING_A = 8'h1C;
    localparam logic [7:0] SUPPLY_CFG_SLEEPING_B = 8'h20;
    localparam logic [7:0] POWER_SEQUENCE_STATUS = 8'h24;
    localparam logic [7:0] SWITCHER_CONTROL      = 8'h2C;
    localparam logic [7:0] SUPPLY_STATUS         = 8'h30;
    localparam logic [7:0] CORE_VOLTAGE_LEVEL    = 8'h34;
    localparam logic [7:0] PLL_REGULATOR_LEVEL   = 8'h40;

    // oscillator field positions
    localparam int SRC_SEL_BIT     = 0;
    localparam int SRC_RESET_BIT   = 1;
    localparam int INT_ENABLE_BIT  = 0;
    localparam int INT_SLOW_BIT    = 1;
    localparam int XTAL_ENABLE_BIT = 0;
    localparam int XTAL_BIAS_BIT   = 1;

    localparam logic [7:0] INTERNAL_OSC_RESET = 8'h01;
    localparam logic [7:0] CRYSTAL_OSC_RESET  = 8'h03;

    // general control field positions
    localparam int GC_SLEEP_CLK_BIT  = 0;
    localparam int GC_SLEEP_REQ_BIT  = 1;
    localparam int GC_PIN_WAKE_BIT   = 2;
    localparam int GC_PIN_POL_BIT    = 3;
    localparam int GC_TIMER_WAKE_BIT = 4;
    localparam int GC_WIDE_CMP_BIT   = 5;
    localparam int GC_REAPPLY_BIT    = 6;
    localparam int GC_POR_LEVEL_BIT  = 7;
    localparam int GC_USB_DOWN_BIT   = 8;
    localparam int GC_USB_UP_BIT     = 9;
    localparam logic [31:0] GC_RESET   = 32'h0000_0008;
    localparam logic [31:0] GC_RW_MASK = 32'h0000_03BD;

    localparam int DWELL_LSB = 16;
    localparam int DWELL_MSB = 20;
    localparam logic [31:0] SUPPLY_CFG_RESET      = 32'h0010_0000;
    localparam logic [31:0] SUPPLY_CFG_RISE_RESET = 32'h0010_0020;
    localparam logic [31:0] SUPPLY_CFG_MASK       = 32'h001F_4333;

    typedef enum logic [1:0] {ORPC_ACC_NONE, ORPC_ACC_8, ORPC_ACC_32} orpc_width_e;
endpackage

// file: verilog/orpc_power_control.sv
// oscillator, counter and power sequencer
// What this block does
// - select bit: 0 crystal, 1 internal oscillator; reset from pin.
// - bit 1 set: select change resets the tile.
// - internal bit 1: 0 fast, 1 slow clock.
// - internal enable resets to 1; clear stops it.
// - crystal bias enable resets to 1; clear turns bias off.
// - crystal enable resets to 1; clear stops crystal.
// - oscillator: peripheral 4, offsets 0x00-0x02, 8-bit only.
// - read-only 64-bit counter, 0x00 low, 0x04 high, peripheral 5.
// - power block: peripheral 6, 32-bit only.
// - control bit 9: USB suspend power-up enable.
// - control bit 8: USB suspend power-down enable.
// - bit 7: power-on default levels on wake.
// - bit 6 write re-applies awake configuration, only while awake; self clearing.
// - bit 5: compare 64 timer bits, else low 32.
// - bit 4: timer reaching wake time ends sleep.
// - bit 3 pin polarity: 1 high wakes, 0 low wakes.
// - bit 2: wake pin at chosen level wakes.
// - bit 1 write starts sleep; self clearing.
// - bit 0 sleep clock: 0 internal slow, 1 default; asleep only.
// - one supply register per state, 0x0C to 0x20.
// - wake time compared only with timer wake on and asleep.
// - asleep dwells minimum, then leaves on timer or pin.
// - five-bit dwell field is log2 of cycles; resets to 16.
`timescale 1ns/1ps
module orpc_power_control (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        src_sel_strap,
    input  wire logic        wake_pin,
    input  wire logic        slow_tick,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [2:0]  req_periph,
    input  wire logic [7:0]  req_addr,
    input  wire logic [1:0]  req_width,
    input  wire logic [31:0] req_wdata,
    output logic             rsp_valid,
    output logic             rsp_error,
    output logic [31:0]      rsp_rdata,
    output logic             use_internal_osc,
    output logic             tile_reset,
    output logic             internal_osc_slow,
    output logic             internal_osc_enable,
    output logic             crystal_bias_enable,
    output logic             crystal_osc_enable,
    output logic             usb_power_up_enable,
    output logic             usb_power_down_enable,
    output logic             use_por_levels,
    output logic             sleep_clk_internal,
    output logic [31:0]      supply_config,
    output logic             supply_apply,
    output logic [2:0]       seq_state
);
    typedef enum logic [2:0] {
        ORPC_AWAKE, ORPC_DESCENT_ONE, ORPC_DESCENT_TWO, ORPC_ASLEEP, ORPC_RISE_ONE, ORPC_RISE_TWO
    } orpc_state_e;

    orpc_state_e state;
    orpc_state_e next_state;
    logic [7:0]  osc_source_select;
    logic [7:0]  internal_osc_control;
    logic [7:0]  crystal_osc_control;
    logic [63:0] rtc_count;
    logic [31:0] power_general_control;
    logic [31:0] wake_time_low;
    logic [31:0] wake_time_high;
    logic [31:0] supply_cfg [0:5];
    logic [31:0] switcher_control;
    logic [31:0] supply_status;
    logic [31:0] core_voltage_level;
    logic [31:0] pll_regulator_level;
    logic        wake_meta;
    logic        wake_sync;
    logic        strap_taken;
    logic        reapply_pending;
    logic [31:0] dwell_count;
    logic [31:0] dwell_limit;
    logic        dwell_done;
    logic        clk_step;
    logic        timer_hit;
    logic        pin_hit;
    logic        osc_acc;
    logic        rtc_acc;
    logic        pwr_acc;
    logic        wr_osc;
    logic        wr_pwr;
    logic        acc_ok;
    logic [2:0]  cfg_index;
    logic        in_cfg;
    logic [7:0]  cfg_off;
    logic [31:0] next_rdata;

    // access decode
    assign osc_acc = req_periph == orpc_pkg::PERIPH_OSC && req_width == orpc_pkg::ORPC_ACC_8
                     && req_addr <= orpc_pkg::CRYSTAL_OSC_CONTROL;
    assign rtc_acc = req_periph == orpc_pkg::PERIPH_RTC && req_width == orpc_pkg::ORPC_ACC_32;
    assign pwr_acc = req_periph == orpc_pkg::PERIPH_PWR && req_width == orpc_pkg::ORPC_ACC_32;
    assign wr_osc  = req_valid && req_write && osc_acc;
    assign wr_pwr  = req_valid && req_write && pwr_acc;
    assign cfg_off = req_addr - orpc_pkg::SUPPLY_CFG_ASLEEP;
    assign in_cfg  = req_addr >= orpc_pkg::SUPPLY_CFG_ASLEEP && req_addr <= orpc_pkg::SUPPLY_CFG_SLEEPING_B
                     && req_addr[1:0] == 2'h0;
    assign cfg_index = cfg_off[4:2];

    always_ff @(posedge clk) begin
        wake_meta <= wake_pin;
        wake_sync <= wake_meta;
    end

    // strap taken after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_source_select <= 8'h00;
            strap_taken       <= 1'b0;
        end else if (!strap_taken) begin
            osc_source_select[orpc_pkg::SRC_SEL_BIT] <= src_sel_strap;
            strap_taken <= 1'b1;
        end else if (wr_osc && req_addr == orpc_pkg::OSC_SOURCE_SELECT) begin
            osc_source_select <= {6'h00, req_wdata[1:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            internal_osc_control <= orpc_pkg::INTERNAL_OSC_RESET;
            crystal_osc_control  <= orpc_pkg::CRYSTAL_OSC_RESET;
        end else begin
            if (wr_osc && req_addr == orpc_pkg::INTERNAL_OSC_CONTROL)
                internal_osc_control <= {6'h00, req_wdata[1:0]};
            if (wr_osc && req_addr == orpc_pkg::CRYSTAL_OSC_CONTROL)
                crystal_osc_control <= {6'h00, req_wdata[1:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            tile_reset <= 1'b0;
        else
            tile_reset <= strap_taken && wr_osc && req_addr == orpc_pkg::OSC_SOURCE_SELECT
                          && osc_source_select[orpc_pkg::SRC_RESET_BIT]
                          && req_wdata[0] != osc_source_select[orpc_pkg::SRC_SEL_BIT];
    end

    assign use_internal_osc    = osc_source_select[orpc_pkg::SRC_SEL_BIT];
    assign internal_osc_slow   = internal_osc_control[orpc_pkg::INT_SLOW_BIT];
    assign internal_osc_enable = internal_osc_control[orpc_pkg::INT_ENABLE_BIT];
    assign crystal_bias_enable = crystal_osc_control[orpc_pkg::XTAL_BIAS_BIT];
    assign crystal_osc_enable  = crystal_osc_control[orpc_pkg::XTAL_ENABLE_BIT];

    always_ff @(posedge clk) begin
        if (reset)
            rtc_count <= 64'h0;
        else
            rtc_count <= rtc_count + 64'h1;
    end

    // sleep request clears while in the first descent state
    always_ff @(posedge clk) begin
        if (reset) begin
            power_general_control <= orpc_pkg::GC_RESET;
        end else begin
            if (wr_pwr && req_addr == orpc_pkg::POWER_GENERAL_CONTROL)
                power_general_control <= (req_wdata & orpc_pkg::GC_RW_MASK)
                                         | {30'h0, req_wdata[orpc_pkg::GC_SLEEP_REQ_BIT], 1'b0};
            else if (state == ORPC_DESCENT_ONE)
                power_general_control[orpc_pkg::GC_SLEEP_REQ_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            reapply_pending <= 1'b0;
        else if (wr_pwr && req_addr == orpc_pkg::POWER_GENERAL_CONTROL && req_wdata[orpc_pkg::GC_REAPPLY_BIT])
            reapply_pending <= 1'b1;
        else
            reapply_pending <= 1'b0;
    end

    assign usb_power_up_enable   = power_general_control[orpc_pkg::GC_USB_UP_BIT];
    assign usb_power_down_enable = power_general_control[orpc_pkg::GC_USB_DOWN_BIT];
    assign use_por_levels        = power_general_control[orpc_pkg::GC_POR_LEVEL_BIT];
    assign sleep_clk_internal    = state == ORPC_ASLEEP
                                   && !power_general_control[orpc_pkg::GC_SLEEP_CLK_BIT];

    // other power registers
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_time_low       <= 32'h0;
            wake_time_high      <= 32'h0;
            switcher_control    <= 32'h0;
            supply_status       <= 32'h0;
            core_voltage_level  <= 32'h0;
            pll_regulator_level <= 32'h0;
        end else if (wr_pwr) begin
            case (req_addr)
                orpc_pkg::WAKE_TIME_LOW:         wake_time_low       <= req_wdata;
                orpc_pkg::WAKE_TIME_HIGH:        wake_time_high      <= req_wdata;
                orpc_pkg::SWITCHER_CONTROL:      switcher_control    <= req_wdata;
                orpc_pkg::SUPPLY_STATUS:         supply_status       <= req_wdata;
                orpc_pkg::CORE_VOLTAGE_LEVEL:    core_voltage_level  <= req_wdata;
                orpc_pkg::PLL_REGULATOR_LEVEL:   pll_regulator_level <= req_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 6; i++)
                supply_cfg[i] <= orpc_pkg::SUPPLY_CFG_RESET;
            supply_cfg[1] <= orpc_pkg::SUPPLY_CFG_RISE_RESET;
        end else if (wr_pwr && in_cfg) begin
            supply_cfg[cfg_index] <= req_wdata & orpc_pkg::SUPPLY_CFG_MASK;
        end
    end

    // state to register index
    function automatic logic [2:0] cfg_of(input orpc_state_e s);
        case (s)
            ORPC_ASLEEP:      cfg_of = 3'h0;
            ORPC_RISE_ONE:    cfg_of = 3'h1;
            ORPC_RISE_TWO:    cfg_of = 3'h2;
            ORPC_AWAKE:       cfg_of = 3'h3;
            ORPC_DESCENT_ONE: cfg_of = 3'h4;
            ORPC_DESCENT_TWO: cfg_of = 3'h5;
            default:          cfg_of = 3'h3;
        endcase
    endfunction

    // dwell counts slow ticks when asleep on internal clock
    assign clk_step    = sleep_clk_internal ? slow_tick : 1'b1;
    assign dwell_limit = 32'h1 << supply_cfg[cfg_of(state)][orpc_pkg::DWELL_MSB:orpc_pkg::DWELL_LSB];
    assign dwell_done  = dwell_count >= dwell_limit;

    always_ff @(posedge clk) begin
        if (reset)
            dwell_count <= 32'h0;
        else if (next_state != state)
            dwell_count <= 32'h0;
        else if (clk_step && !dwell_done)
            dwell_count <= dwell_count + 32'h1;
    end

    assign timer_hit = state == ORPC_ASLEEP && power_general_control[orpc_pkg::GC_TIMER_WAKE_BIT]
                       && rtc_count[31:0] >= wake_time_low
                       && (!power_general_control[orpc_pkg::GC_WIDE_CMP_BIT]
                           || rtc_count[63:32] >= wake_time_high);
    assign pin_hit   = power_general_control[orpc_pkg::GC_PIN_WAKE_BIT]
                       && wake_sync == power_general_control[orpc_pkg::GC_PIN_POL_BIT];

    always_comb begin
        next_state = state;
        case (state)
            ORPC_AWAKE:       if (power_general_control[orpc_pkg::GC_SLEEP_REQ_BIT]) next_state = ORPC_DESCENT_ONE;
            ORPC_DESCENT_ONE: if (dwell_done) next_state = ORPC_DESCENT_TWO;
            ORPC_DESCENT_TWO: if (dwell_done) next_state = ORPC_ASLEEP;
            ORPC_ASLEEP:      if (dwell_done && (timer_hit || pin_hit)) next_state = ORPC_RISE_ONE;
            ORPC_RISE_ONE:    if (dwell_done) next_state = ORPC_RISE_TWO;
            ORPC_RISE_TWO:    if (dwell_done) next_state = ORPC_AWAKE;
            default:          next_state = ORPC_AWAKE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset)
            state <= ORPC_AWAKE;
        else
            state <= next_state;
    end

    // apply on state entry or re-apply
    always_ff @(posedge clk) begin
        if (reset) begin
            supply_config <= orpc_pkg::SUPPLY_CFG_RESET;
            supply_apply  <= 1'b0;
        end else begin
            supply_apply <= 1'b0;
            if (next_state != state) begin
                supply_config <= supply_cfg[cfg_of(next_state)];
                supply_apply  <= 1'b1;
            end else if (reapply_pending && state == ORPC_AWAKE) begin
                supply_config <= supply_cfg[3'h3];
                supply_apply  <= 1'b1;
            end
        end
    end

    assign seq_state = state;

    always_comb begin
        next_rdata = 32'h0;
        acc_ok     = 1'b1;
        if (osc_acc) begin
            case (req_addr)
                orpc_pkg::OSC_SOURCE_SELECT:    next_rdata = {24'h0, osc_source_select};
                orpc_pkg::INTERNAL_OSC_CONTROL: next_rdata = {24'h0, internal_osc_control};
                default:                        next_rdata = {24'h0, crystal_osc_control};
            endcase
        end else if (rtc_acc) begin
            case (req_addr)
                orpc_pkg::RTC_COUNT_LOW:  next_rdata = rtc_count[31:0];
                orpc_pkg::RTC_COUNT_HIGH: next_rdata = rtc_count[63:32];
                default:                  acc_ok = 1'b0;
            endcase
        end else if (pwr_acc) begin
            if (in_cfg)
                next_rdata = supply_cfg[cfg_index];
            else begin
                case (req_addr)
                    orpc_pkg::POWER_GENERAL_CONTROL: next_rdata = power_general_control;
                    orpc_pkg::WAKE_TIME_LOW:         next_rdata = wake_time_low;
                    orpc_pkg::WAKE_TIME_HIGH:        next_rdata = wake_time_high;
                    orpc_pkg::POWER_SEQUENCE_STATUS: next_rdata = {29'h0, state};
                    orpc_pkg::SWITCHER_CONTROL:      next_rdata = switcher_control;
                    orpc_pkg::SUPPLY_STATUS:         next_rdata = supply_status;
                    orpc_pkg::CORE_VOLTAGE_LEVEL:    next_rdata = core_voltage_level;
                    orpc_pkg::PLL_REGULATOR_LEVEL:   next_rdata = pll_regulator_level;
                    default:                         acc_ok = 1'b0;
                endcase
            end
        end else begin
            acc_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= 32'h0;
        end else begin
            rsp_valid <= req_valid;
            rsp_error <= req_valid && !acc_ok;
            rsp_rdata <= (req_valid && !req_write && acc_ok) ? next_rdata : 32'h0;
        end
    end
endmodule

// file: verification/orpc_power_control_asserts.sv
// checker for the power control block
`timescale 1ns/1ps
module orpc_power_control_asserts (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [2:0]  req_periph,
    input wire logic [1:0]  req_width,
    input wire logic        rsp_valid,
    input wire logic        rsp_error,
    input wire logic [31:0] rsp_rdata,
    input wire logic        usb_power_up_enable,
    input wire logic        usb_power_down_enable,
    input wire logic        use_por_levels,
    input wire logic        sleep_clk_internal,
    input wire logic        supply_apply,
    input wire logic [2:0]  seq_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_osc_bad; req_valid && req_periph == 3'h4 && req_width != 2'h1; endsequence
    sequence s_rtc_bad; req_valid && req_periph == 3'h5 && req_width != 2'h2; endsequence
    sequence s_pwr_bad; req_valid && req_periph == 3'h6 && req_width != 2'h2; endsequence
    property p_answer; req_valid |=> rsp_valid; endproperty
    property p_no_spurious; !req_valid |=> !rsp_valid; endproperty
    property p_osc_width; s_osc_bad |=> rsp_error; endproperty
    property p_rtc_width; s_rtc_bad |=> rsp_error; endproperty
    property p_pwr_width; s_pwr_bad |=> rsp_error; endproperty
    property p_write_rdata; req_valid && req_write |=> rsp_rdata == 32'h0000_0000; endproperty
    property p_gc_hold; !req_valid |=> $stable({usb_power_up_enable, usb_power_down_enable, use_por_levels}); endproperty
    property p_order;
        seq_state != $past(seq_state) |-> seq_state == (($past(seq_state) == 3'h5) ? 3'h0 : $past(seq_state) + 3'h1);
    endproperty
    property p_apply; $changed(seq_state) |-> ##[0:1] supply_apply; endproperty
    property p_sleep_clk; sleep_clk_internal |-> seq_state == 3'h3; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    a_no_spurious: assert property (p_no_spurious) else $error("stray answer");
    a_osc_width: assert property (p_osc_width) else $error("bad osc width");
    a_rtc_width: assert property (p_rtc_width) else $error("bad rtc width");
    a_pwr_width: assert property (p_pwr_width) else $error("bad pwr width");
    a_write_rdata: assert property (p_write_rdata) else $error("write data");
    a_gc_hold: assert property (p_gc_hold) else $error("bits moved");
    a_order: assert property (p_order) else $error("bad order");
    a_apply: assert property (p_apply) else $error("no apply");
    a_sleep_clk: assert property (p_sleep_clk) else $error("slow clock awake");
endmodule
bind orpc_power_control orpc_power_control_asserts u_asserts (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_write(req_write), .req_periph(req_periph), .req_width(req_width), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .usb_power_up_enable(usb_power_up_enable),
    .usb_power_down_enable(usb_power_down_enable), .use_por_levels(use_por_levels),
    .sleep_clk_internal(sleep_clk_internal), .supply_apply(supply_apply), .seq_state(seq_state));

// file: verification/tb.sv
// bench for the power control block
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        src_sel_strap = 1'b1;
    logic        wake_pin = 1'b0;
    logic        slow_tick = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [2:0]  req_periph = 3'h0;
    logic [7:0]  req_addr = 8'h00;
    logic [1:0]  req_width = 2'h0;
    logic [31:0] req_wdata = 32'h0000_0000;
    logic        rsp_valid, rsp_error, use_internal_osc, tile_reset, internal_osc_slow, internal_osc_enable;
    logic        crystal_bias_enable, crystal_osc_enable, usb_power_up_enable, usb_power_down_enable;
    logic        use_por_levels, sleep_clk_internal, supply_apply;
    logic [31:0] rsp_rdata, supply_config, rd, tgt;
    logic [2:0]  seq_state, last_state = 3'h0, tick_div = 3'h0;
    logic        err;
    int          failures = 0, cmp_count = 0, tile_resets = 0;
    logic [31:0] cfg_q[$];
    logic [2:0]  state_q[$];
    logic [7:0]  cfg_adr [6] = '{8'h1C, 8'h20, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] cfg_val [6] = '{32'h0001_0001, 32'h0001_0010, 32'h0001_0020, 32'h0001_0011, 32'h0001_0021,
                                 32'h0001_0031};
    logic [2:0]  e_per [5] = '{3'h4, 3'h6, 3'h5, 3'h7, 3'h4};
    logic [7:0]  e_adr [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h03};
    logic [1:0]  e_w [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1};

    orpc_power_control uut (.clk(clk), .reset(reset), .src_sel_strap(src_sel_strap), .wake_pin(wake_pin),
        .slow_tick(slow_tick), .req_valid(req_valid), .req_write(req_write), .req_periph(req_periph),
        .req_addr(req_addr), .req_width(req_width), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .use_internal_osc(use_internal_osc),
        .tile_reset(tile_reset), .internal_osc_slow(internal_osc_slow), .internal_osc_enable(internal_osc_enable),
        .crystal_bias_enable(crystal_bias_enable), .crystal_osc_enable(crystal_osc_enable),
        .usb_power_up_enable(usb_power_up_enable), .usb_power_down_enable(usb_power_down_enable),
        .use_por_levels(use_por_levels), .sleep_clk_internal(sleep_clk_internal), .supply_config(supply_config),
        .supply_apply(supply_apply), .seq_state(seq_state));

    always #2 clk = ~clk;

    // slow tick; records pulses and state entries
    always @(posedge clk) begin
        tick_div <= tick_div + 3'h1;
        slow_tick <= (tick_div == 3'h7);
        if (tile_reset === 1'b1) tile_resets++;
        if (supply_apply === 1'b1) cfg_q.push_back(supply_config);
        if (seq_state !== last_state) state_q.push_back(seq_state);
        last_state = seq_state;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [2:0] per, input logic [7:0] adr, input logic [1:0] w,
                       input logic [31:0] wd);
        req_valid = 1'b1;
        req_write = wr;
        req_periph = per;
        req_addr = adr;
        req_width = w;
        req_wdata = wd;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        rd = (w == 2'h1) ? {24'h0, rsp_rdata[7:0]} : rsp_rdata;
        err = rsp_error;
        check("rsp_valid", 32'h1, {31'h0, rsp_valid});
        @(posedge clk);
        #1;
    endtask

    task automatic rdchk(input string name, input logic [2:0] per, input logic [7:0] adr, input logic [1:0] w,
                         input logic [31:0] exp);
        acc(1'b0, per, adr, w, 32'h0000_0000);
        check(name, exp, rd);
    endtask

    task automatic wait_state(input logic [2:0] s, input int lim);
        int n;
        n = 0;
        while (seq_state !== s && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        check("seq_state", {29'h0, s}, {29'h0, seq_state});
    endtask

    task automatic t_reset_values;
        rdchk("osc_source_select", 3'h4, 8'h00, 2'h1, 32'h01);
        rdchk("internal_osc_control", 3'h4, 8'h01, 2'h1, 32'h01);
        rdchk("crystal_osc_control", 3'h4, 8'h02, 2'h1, 32'h03);
        rdchk("power_general_control", 3'h6, 8'h00, 2'h2, orpc_pkg::GC_RESET);
        rdchk("supply_cfg_asleep", 3'h6, 8'h0C, 2'h2, orpc_pkg::SUPPLY_CFG_RESET);
        rdchk("rtc_count_high", 3'h5, 8'h04, 2'h2, 32'h0);
        check("use_internal_osc", 32'h1, {31'h0, use_internal_osc});
    endtask

    task automatic t_refusals;
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, e_per[i], e_adr[i], e_w[i], 32'h0);
            check("rsp_error", 32'h1, {31'h0, err});
        end
        check("internal_osc_enable", 32'h1, {31'h0, internal_osc_enable});
        acc(1'b1, 3'h5, 8'h04, 2'h2, 32'hFFFF_FFFF);
        check("rtc_write_error", 32'h0, {31'h0, err});
        rdchk("rtc_count_high", 3'h5, 8'h04, 2'h2, 32'h0);
    endtask

    task automatic t_oscillator;
        acc(1'b1, 3'h4, 8'h00, 2'h1, 32'h03);
        acc(1'b1, 3'h4, 8'h00, 2'h1, 32'h02);
        repeat (4) @(posedge clk);
        #1;
        check("tile_resets", 32'h1, tile_resets);
        check("use_internal_osc", 32'h0, {31'h0, use_internal_osc});
        acc(1'b1, 3'h4, 8'h01, 2'h1, 32'h02);
        check("osc_slow_off", 32'h2, {30'h0, internal_osc_slow, internal_osc_enable});
        acc(1'b1, 3'h4, 8'h01, 2'h1, 32'h01);
        acc(1'b1, 3'h4, 8'h00, 2'h1, 32'h00);
        acc(1'b1, 3'h4, 8'h00, 2'h1, 32'h01);
        repeat (4) @(posedge clk);
        #1;
        check("tile_resets", 32'h1, tile_resets);
        acc(1'b1, 3'h4, 8'h02, 2'h1, 32'h00);
        check("crystal_bits", 32'h0, {30'h0, crystal_bias_enable, crystal_osc_enable});
        rdchk("crystal_osc_control", 3'h4, 8'h02, 2'h1, 32'h00);
        acc(1'b1, 3'h4, 8'h02, 2'h1, 32'h03);
    endtask

    task automatic t_general_control;
        int n;
        acc(1'b1, 3'h6, 8'h00, 2'h2, 32'h0000_03A8);
        check("usb_por_bits", 32'h7, {29'h0, usb_power_up_enable, usb_power_down_enable, use_por_levels});
        rdchk("power_general_control", 3'h6, 8'h00, 2'h2, 32'h0000_03A8);
        n = cfg_q.size();
        acc(1'b1, 3'h6, 8'h00, 2'h2, 32'h0000_0048);
        @(posedge clk);
        #1;
        check("reapply_count", n + 1, cfg_q.size());
        check("reapply_cfg", orpc_pkg::SUPPLY_CFG_RESET, supply_config);
        rdchk("power_general_control", 3'h6, 8'h00, 2'h2, 32'h0000_0008);
    endtask

    task automatic t_pin_sleep;
        for (int i = 0; i < 6; i++) acc(1'b1, 3'h6, cfg_adr[i], 2'h2, cfg_val[i]);
        acc(1'b1, 3'h6, 8'h04, 2'h2, 32'h0);
        acc(1'b1, 3'h6, 8'h08, 2'h2, 32'h1);
        cfg_q.delete();
        state_q.delete();
        acc(1'b1, 3'h6, 8'h00, 2'h2, 32'h0000_003F);
        wait_state(3'h3, 200);
        repeat (20) @(posedge clk);
        #1;
        check("still_asleep", 32'h3, {29'h0, seq_state});
        check("sleep_clk_internal", 32'h0, {31'h0, sleep_clk_internal});
        rdchk("power_general_control", 3'h6, 8'h00, 2'h2, 32'h0000_003D);
        wake_pin = 1'b1;
        wait_state(3'h0, 100);
        wake_pin = 1'b0;
        check("state_entries", 32'h6, state_q.size());
        check("apply_entries", 32'h6, cfg_q.size());
        for (int i = 0; i < 6; i++) begin
            check("state_order", (i + 1) % 6, {29'h0, state_q[i]});
            check("entry_cfg", cfg_val[i], cfg_q[i]);
        end
    endtask

    task automatic t_timer_sleep;
        rdchk("rtc_count_high", 3'h5, 8'h04, 2'h2, 32'h0);
        acc(1'b0, 3'h5, 8'h00, 2'h2, 32'h0);
        tgt = rd + 32'd300;
        acc(1'b1, 3'h6, 8'h04, 2'h2, tgt);
        acc(1'b1, 3'h6, 8'h00, 2'h2, 32'h0000_0012);
        wait_state(3'h3, 200);
        check("sleep_clk_internal", 32'h1, {31'h0, sleep_clk_internal});
        wait_state(3'h0, 800);
        acc(1'b0, 3'h5, 8'h00, 2'h2, 32'h0);
        check("woke_after_target", 32'h1, {31'h0, rd >= tgt});
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        @(posedge clk);
        #1;
        t_reset_values();
        t_refusals();
        t_oscillator();
        t_general_control();
        t_pin_sleep();
        t_timer_sleep();
        stop_test();
    end
endmodule
